// >>> rtl/ocpwm_top.sv
`timescale 1ns/1ps
module ocpwm_top
  import ocpwm_pkg::*;
(
  input  wire logic              SYS_CLK,
  input  wire logic              SYS_RST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [APB_AW-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output logic                   COMPARE_OUTPUT_PIN
);
  logic              ctrl_en;
  ocpwm_mode_e       ctrl_mode;
  logic [PS_W-1:0]   ctrl_ps;
  logic [DATA_W-1:0] primary_compare_reg;
  logic [DATA_W-1:0] secondary_compare_period_reg;
  logic [DATA_W-1:0] sync_timer_period_reg;
  logic [31:0]       stat;
  logic [31:0]       prdata_c;
  logic              pready_c;
  logic              pslverr_c;
  logic              tick;
  logic [PS_CNT_W-1:0] div_m1;

  // Active (latched) copies
  logic [DATA_W-1:0] act_pri_q;
  logic [DATA_W-1:0] act_sec_q;
  logic [DATA_W-1:0] act_tpr_q;
  ocpwm_mode_e       act_mode_q;
  logic [DATA_W-1:0] tb_q;
  logic              pin_q;
  logic              run_q;
  logic              end_c;
  logic [DATA_W-1:0] per_c;
  logic              pin_d;

  ocpwm_apb u_apb
  (
    .SYS_CLK   (SYS_CLK),
    .SYS_RST   (SYS_RST),
    .psel      (PSEL),
    .penable   (PENABLE),
    .pwrite    (PWRITE),
    .paddr     (PADDR),
    .pwdata    (PWDATA),
    .stat      (stat),
    .prdata    (prdata_c),
    .pready    (pready_c),
    .pslverr   (pslverr_c),
    .ctrl_en   (ctrl_en),
    .ctrl_mode (ctrl_mode),
    .ctrl_ps   (ctrl_ps),
    .pri_q     (primary_compare_reg),
    .sec_q     (secondary_compare_period_reg),
    .tpr_q     (sync_timer_period_reg)
  );

  // Prescale 1,4,8,64 times the two-clock instruction cycle
  always_comb
  begin
    unique case (ctrl_ps)
      2'h0:    div_m1 = PS_CNT_W'(TOSC_PER_TCY * 1 - 1);
      2'h1:    div_m1 = PS_CNT_W'(TOSC_PER_TCY * 4 - 1);
      2'h2:    div_m1 = PS_CNT_W'(TOSC_PER_TCY * 8 - 1);
      default: div_m1 = PS_CNT_W'(TOSC_PER_TCY * 64 - 1);
    endcase
  end

  ocpwm_tick u_tick
  (
    .SYS_CLK (SYS_CLK),
    .SYS_RST (SYS_RST),
    .en      (ctrl_en),
    .div_m1  (div_m1),
    .tick    (tick)
  );

  // Period selection by active mode
  always_comb
  begin
    if (act_mode_q == OCPWM_EDGE)
      per_c = act_sec_q;
    else
      per_c = act_tpr_q;
  end

  // Period end: both modes count up and wrap, so a period is value+1 ticks
  always_comb
  begin
    end_c = (tb_q == per_c);
  end

  // Time base; one tick per prescaled instruction cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST || !ctrl_en)
      tb_q <= '0;
    else if (tick)
    begin
      if (end_c)
        tb_q <= '0;
      else
        tb_q <= tb_q + 1'b1;
    end
  end

  // Double buffer; loaded at start and on each period end
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      act_pri_q  <= REG_RST;
      act_sec_q  <= REG_RST;
      act_tpr_q  <= REG_RST;
      act_mode_q <= OCPWM_EDGE;
      run_q      <= 1'b0;
    end
    else
    begin
      run_q <= ctrl_en;
      if (!run_q || (tick && end_c))
      begin
        act_pri_q  <= primary_compare_reg;
        act_sec_q  <= secondary_compare_period_reg;
        act_tpr_q  <= sync_timer_period_reg;
        act_mode_q <= ctrl_mode;
      end
    end
  end

  // Output level; boundary cases first
  always_comb
  begin
    pin_d = 1'b0;
    if (!run_q)
      pin_d = 1'b0;
    else if (act_mode_q == OCPWM_EDGE)
    begin
      if (act_pri_q == '0 && act_sec_q == '0)
        pin_d = 1'b0;
      else if (act_sec_q > act_pri_q)
        pin_d = 1'b1;
      else
        pin_d = (tb_q < act_pri_q);
    end
    else
    begin
      if (act_pri_q == '0 && act_sec_q == '0 && act_tpr_q == '0)
        pin_d = 1'b0;
      else if (act_sec_q > act_tpr_q)
        pin_d = 1'b1;
      else
        // High in the window between primary and secondary marks
        pin_d = (tb_q >= act_pri_q) && (tb_q < act_sec_q);
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      pin_q <= 1'b0;
    else
      pin_q <= pin_d;
  end

  assign COMPARE_OUTPUT_PIN = pin_q;

  always_comb
  begin
    stat = '0;
    stat[STAT_PIN_BIT]              = pin_q;
    stat[STAT_TB_LSB +: DATA_W]     = tb_q;
  end

  // APB answers come from flops in the register block
  assign PRDATA  = prdata_c;
  assign PREADY  = pready_c;
  assign PSLVERR = pslverr_c;
endmodule

// >>> include/ocpwm_pkg.sv
package ocpwm_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned APB_AW = 8;
  // Register byte addresses
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_PRI  = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_SEC  = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_TPR  = 8'h0C;
  localparam logic [APB_AW-1:0] ADDR_STAT = 8'h10;
  // Control field positions
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_CTR_BIT = 1;
  localparam int unsigned CTRL_PS_LSB  = 2;
  localparam int unsigned PS_W         = 2;
  // Status field positions
  localparam int unsigned STAT_PIN_BIT = 0;
  localparam int unsigned STAT_DIR_BIT = 1;
  localparam int unsigned STAT_TB_LSB  = 16;
  // Reset values
  localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
  localparam logic [PS_W-1:0]   PS_RST  = 2'h0;
  // Instruction cycle is two oscillator (SYS_CLK) periods
  localparam int unsigned TOSC_PER_TCY = 2;
  localparam int unsigned PS_CNT_W     = 8;
  typedef enum logic {OCPWM_EDGE, OCPWM_CENTER} ocpwm_mode_e;
endpackage

// >>> rtl/ocpwm_tick.sv
`timescale 1ns/1ps
module ocpwm_tick
  import ocpwm_pkg::*;
(
  input  wire logic                SYS_CLK,
  input  wire logic                SYS_RST,
  input  wire logic                en,
  input  wire logic [PS_CNT_W-1:0] div_m1,
  output logic                     tick
);
  logic [PS_CNT_W-1:0] cnt_q;

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST || !en)
    begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end
    else if (cnt_q == div_m1)
    begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule

// >>> rtl/ocpwm_apb.sv
`timescale 1ns/1ps
module ocpwm_apb
  import ocpwm_pkg::*;
(
  input  wire logic              SYS_CLK,
  input  wire logic              SYS_RST,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [31:0]       stat,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   ctrl_en,
  output ocpwm_mode_e            ctrl_mode,
  output logic      [PS_W-1:0]   ctrl_ps,
  output logic      [DATA_W-1:0] pri_q,
  output logic      [DATA_W-1:0] sec_q,
  output logic      [DATA_W-1:0] tpr_q
);
  logic        acc;
  logic        setup;
  logic        wr;
  logic        hit;
  logic [31:0] rd_c;

  assign acc   = psel && penable;
  assign setup = psel && !penable;
  assign wr  = acc && pwrite;
  assign hit = (paddr == ADDR_CTRL) || (paddr == ADDR_PRI) ||
               (paddr == ADDR_SEC) || (paddr == ADDR_TPR) ||
               (paddr == ADDR_STAT);

  // Answer loaded at the setup edge, so it stands for the whole access
  // phase; still zero wait states, and every bus output is a flop
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !hit;
      prdata  <= setup ? rd_c : '0;
    end
  end

  // Writes accepted at any time; pwm core decides when they apply
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      ctrl_en   <= 1'b0;
      ctrl_mode <= OCPWM_EDGE;
      ctrl_ps   <= PS_RST;
      pri_q     <= REG_RST;
      sec_q     <= REG_RST;
      tpr_q     <= REG_RST;
    end
    else if (wr)
    begin
      unique case (paddr)
        ADDR_CTRL:
        begin
          ctrl_en   <= pwdata[CTRL_EN_BIT];
          ctrl_mode <= ocpwm_mode_e'(pwdata[CTRL_CTR_BIT]);
          ctrl_ps   <= pwdata[CTRL_PS_LSB +: PS_W];
        end
        ADDR_PRI: pri_q <= pwdata[DATA_W-1:0];
        ADDR_SEC: sec_q <= pwdata[DATA_W-1:0];
        ADDR_TPR: tpr_q <= pwdata[DATA_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb
  begin
    rd_c = '0;
    unique case (paddr)
      ADDR_CTRL:
      begin
        rd_c[CTRL_EN_BIT]             = ctrl_en;
        rd_c[CTRL_CTR_BIT]            = ctrl_mode;
        rd_c[CTRL_PS_LSB +: PS_W]     = ctrl_ps;
      end
      ADDR_PRI:  rd_c[DATA_W-1:0] = pri_q;
      ADDR_SEC:  rd_c[DATA_W-1:0] = sec_q;
      ADDR_TPR:  rd_c[DATA_W-1:0] = tpr_q;
      ADDR_STAT: rd_c = stat;
      default:   rd_c = '0;
    endcase
  end
endmodule

// >>> tb/ocpwm_top_properties.sv
`timescale 1ns/1ps
module ocpwm_chk
  import ocpwm_pkg::*;
(
  input wire logic              SYS_CLK,
  input wire logic              SYS_RST,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic              COMPARE_OUTPUT_PIN
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  logic acc;
  logic map;
  assign acc = PSEL && PENABLE;
  assign map = PADDR inside {ADDR_CTRL, ADDR_PRI, ADDR_SEC, ADDR_TPR, ADDR_STAT};
  sequence s_acc; PSEL && PENABLE; endsequence
  sequence s_off; !COMPARE_OUTPUT_PIN [*2]; endsequence
  property p_rdy; s_acc |-> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  property p_err; s_acc |-> PSLVERR == !map; endproperty
  a_err: assert property (p_err) else $error("wrong slave error");
  property p_idle; !acc |-> !PSLVERR; endproperty
  a_idle: assert property (p_idle) else $error("error outside access");
  property p_rd0; acc && !PWRITE && !map |-> PRDATA == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
  property p_hi;
    acc && !PWRITE && map && PADDR != ADDR_STAT |-> PRDATA[31:16] == 16'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_pin;
    acc && !PWRITE && PADDR == ADDR_STAT
      |-> PRDATA[STAT_PIN_BIT] == $past(COMPARE_OUTPUT_PIN);
  endproperty
  a_pin: assert property (p_pin) else $error("status pin mismatch");
  // Enable, run and pin flops in turn, hence three cycles
  property p_dis;
    acc && PWRITE && PADDR == ADDR_CTRL && !PWDATA[CTRL_EN_BIT] |-> ##3 s_off;
  endproperty
  a_dis: assert property (p_dis) else $error("pin not low when disabled");
  property p_rst; $fell(SYS_RST) |-> !COMPARE_OUTPUT_PIN; endproperty
  a_rst: assert property (p_rst) else $error("pin high after reset");
endmodule
bind ocpwm_top ocpwm_chk u_chk (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR),
  .COMPARE_OUTPUT_PIN(COMPARE_OUTPUT_PIN)
);

// >>> tb/ocpwm_load.sv
`timescale 1ns/1ps
module ocpwm_load (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   pin,
  output logic        ev,
  output logic [15:0] hi,
  output logic [15:0] per
);
  logic        pin_q;
  logic [15:0] cnt_q;
  logic [15:0] hcnt_q;
  // Reports the period that ends at each rising edge
  always_ff @(posedge clk)
    if (rst)
    begin
      ev <= 1'b0;
      pin_q <= 1'b0;
    end
    else
    begin
      pin_q <= pin;
      ev <= pin && !pin_q;
      cnt_q <= (pin && !pin_q) ? 16'h1 : cnt_q + 16'h1;
      hcnt_q <= (pin && !pin_q) ? 16'h1 : hcnt_q + 16'(pin);
      if (pin && !pin_q)
      begin
        per <= cnt_q;
        hi <= hcnt_q;
      end
    end
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import ocpwm_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              psel = 1'b0;
  logic              pen = 1'b0;
  logic              pwr = 1'b0;
  logic [APB_AW-1:0] padr = '0;
  logic [31:0]       pwd = '0;
  logic [31:0]       rdat;
  logic              rdy;
  logic              pin;
  logic              ev;
  logic [15:0]       hi;
  logic [15:0]       per;
  logic [31:0]       q_rd[$];
  logic [31:0]       q_pw[$];
  logic [31:0]       rnd = 32'h0001367C;
  int                r[4] = '{1, 4, 8, 64};
  int                n_fail = 0;
  int                comparisons = 0;
  initial forever #20 clk = ~clk;
  ocpwm_top DUT (.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(rdat), .PREADY(rdy),
    .PSLVERR(), .COMPARE_OUTPUT_PIN(pin));
  ocpwm_load u_ld (.clk(clk), .rst(rst), .pin(pin), .ev(ev), .hi(hi),
    .per(per));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic close_out();
    if (q_rd.size() + q_pw.size() > 0)
      bad("notes left");
    $display("fails %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bad(input string m);
    n_fail++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic tmo();
    bad("wait expired");
    close_out();
  endtask
  // For reads, d is the expected data
  task automatic xfer(input logic w, input logic [APB_AW-1:0] a,
                      input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= w ? d : rnd;
    @(posedge clk);
    pen <= 1'b1;
    if (!w)
      q_rd.push_back(d);
    @(posedge clk);
    while (rdy !== 1'b1)
    begin
      k++;
      if (k > 50)
        tmo();
      @(posedge clk);
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  always @(posedge clk)
    if (psel && pen && !pwr && rdy === 1'b1 && q_rd.size() > 0)
    begin
      comparisons++;
      if (rdat !== q_rd.pop_front())
        bad("read data");
    end
  always @(posedge clk)
    if (ev === 1'b1 && q_pw.size() > 0)
    begin
      comparisons++;
      if ({hi, per} !== q_pw.pop_front())
        bad("pwm shape");
    end
  // Ends one cycle after the event so the note is not consumed early
  task automatic wait_ev(input int n);
    int k;
    k = 0;
    repeat (n)
    begin
      @(negedge clk);
      while (ev !== 1'b1)
      begin
        k++;
        if (k > 4000)
          tmo();
        @(negedge clk);
      end
      @(negedge clk);
    end
  endtask
  task automatic cfg(input logic [31:0] c, input logic [15:0] p, s, t);
    xfer(1'b1, ADDR_CTRL, 32'h0);
    xfer(1'b1, ADDR_PRI, {16'h0, p});
    xfer(1'b1, ADDR_SEC, {16'h0, s});
    xfer(1'b1, ADDR_TPR, {16'h0, t});
    xfer(1'b1, ADDR_CTRL, c);
  endtask
  task automatic level(input logic [31:0] c, input logic [15:0] p, s, t,
                       input logic v);
    cfg(c, p, s, t);
    repeat (4) @(posedge clk);
    repeat (60)
    begin
      @(negedge clk);
      comparisons++;
      if (pin !== v)
        bad("pin level");
    end
  endtask
  task automatic shape(input logic [31:0] c, input logic [15:0] p, s, t, h, n);
    cfg(c, p, s, t);
    wait_ev(2);
    q_pw.push_back({h, n});
    wait_ev(1);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      xfer(1'b0, APB_AW'(i * 4), 32'h0);
    for (int i = 1; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      xfer(1'b1, APB_AW'(i * 4), rnd);
      xfer(1'b0, APB_AW'(i * 4), {16'h0, rnd[15:0]});
    end
    level(32'h1, 16'h0, 16'h0, 16'h0, 1'b0);
    level(32'h1, 16'h2, 16'h5, 16'h0, 1'b1);
    level(32'h3, 16'h0, 16'h0, 16'h0, 1'b0);
    level(32'h3, 16'h3, 16'h5, 16'h2, 1'b1);
    for (int i = 0; i < 4; i++)
      shape(32'(i * 4 + 1), 2, 2, 0, 16'(4 * r[i]), 16'(6 * r[i]));
    shape(32'h3, 16'h0, 16'h3, 16'h4, 16'h0006, 16'h000A);
    shape(32'h1, 16'h5, 16'h5, 16'h9, 16'h000A, 16'h000C);
    q_pw.push_back({16'h000A, 16'h000C});
    xfer(1'b1, ADDR_PRI, 32'h2);
    xfer(1'b1, ADDR_SEC, 32'h2);
    q_pw.push_back({16'h0004, 16'h0006});
    wait_ev(3);
    close_out();
  end
endmodule
